/* File: pkg/lcsc_pkg.sv */
/*
  Package for the line card serial control block: register layout,
  field positions, reset values, timing counts and carrier types.
  Assumes a 40 MHz system clock and a controller shift clock of at
  most 128 kHz sampled as an ordinary asynchronous input.
*/
package lcsc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLOCK_HZ = 40_000_000;
  localparam int SHIFT_CLOCK_MAX_HZ = 128_000;
  // Least shift clock period in system cycles, rounded down
  localparam int SHIFT_PERIOD_CYCLES = CLOCK_HZ / SHIFT_CLOCK_MAX_HZ;

  // ==========================================================
  // Frame sizes
  // ==========================================================
  localparam int WRITE_BITS = 8;
  localparam int STATUS_BITS = 12;
  localparam logic [3:0] WRITE_LAST = 4'h7;
  localparam logic [3:0] STATUS_LAST = 4'hB;

  // ==========================================================
  // Written byte fields
  // ==========================================================
  localparam int SEL_BIT = 0;
  localparam int VALID_BIT = 7;
  localparam logic SEL_FEED = 1'b0;
  localparam logic SEL_CONTROL = 1'b1;

  // Feed configuration
  localparam int FEED_STANDBY = 1;
  localparam int FEED_SPECIAL = 2;
  localparam int FEED_REAL_BATT = 3;
  localparam int FEED_LIM30 = 4;
  localparam int FEED_LIM20 = 5;
  localparam int FEED_LIM12 = 6;
  localparam logic [5:0] LIMIT_STEP30 = 6'h1E;
  localparam logic [5:0] LIMIT_STEP20 = 6'h14;
  localparam logic [5:0] LIMIT_STEP12 = 6'h0C;

  // Line control
  localparam int CTRL_GPO = 1;
  localparam int CTRL_AIO_OUT = 2;
  localparam int CTRL_TAX_ON = 3;
  localparam int CTRL_REVERSE = 4;
  localparam int CTRL_RING = 5;
  localparam int CTRL_TAX_NOVAR = 6;

  // Status word fields
  localparam int ST_HOOK = 0;
  localparam int ST_CMP = 1;
  localparam int ST_GK = 2;
  localparam int ST_TW = 3;
  localparam int ST_ECHO_LO = 4;

  // Reset values: standby with no current limit means power down
  localparam logic [7:0] FEED_RESET = 8'h02;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] ECHO_RESET = 8'h00;

  // ==========================================================
  // Carrier types
  // ==========================================================
  typedef struct packed {
    logic hookState;
    logic compareResult;
    logic groundKeyFlag;
    logic thermalOver;
  } lcsc_line_sense_s;

  typedef struct packed {
    logic standbyState;
    logic talkState;
    logic powerDownState;
    logic specialChar;
    logic realBattery;
    logic [5:0] currentLimitMa;
    logic generalPurposeOutput;
    logic analogIoOutMode;
    logic taxPulseOn;
    logic reverseBattery;
    logic taxDropNoVariation;
    logic ringRelay;
  } lcsc_line_drive_s;

endpackage : lcsc_pkg

/* File: rtl/lcsc_serial_control.sv */
/*
  Line card serial control: four-wire serial slave carrying two
  write-only configuration bytes and a twelve-bit status word, the
  decoded line state, and ring relay control.
  Assumes shiftClk, chipSelN, readWriteSel, dataIn and all line sense
  inputs are asynchronous to clock; the analog front end supplies
  ring zero crossing and ring trip pulses as levels from comparators.
*/
// Contract
// R1 - With select low and write mode, capture a data bit per clock rise.
// R2 - With select low and read mode, shift output word per clock rise.
// R3 - On read, bit zero appears at select, and again at first rise.
// R4 - Data pin released whenever chip select is high.
// R5 - Controller keeps shift clock at or below 128 kHz.
// R6 - Bit zero travels first, higher bits follow in order.
// R7 - Written bit zero picks feed byte (0) or control byte (1).
// R8 - Commit byte at select rise only when bit seven is one.
// R9 - Feed bits: 1 standby, 2 special characteristic, 3 real battery.
// R10 - Feed bits 4,5,6 add 30, 20, 12 mA to current limit.
// R11 - Power down when standby set and all limit bits clear.
// R12 - Control bits: 1 general output, 2 analog pin mode, 3 tax on.
// R13 - Control bits: 4 reverse battery, 5 ringing, 6 no tax variation.
// R14 - Status: hook, compare, ground key, thermal in bits zero to three.
// R15 - Status bits 4 to 11 echo the last byte written.
// R16 - Thermal flag reads one while temperature exceeds threshold.
// R17 - Ring relay energised only at a ringing zero crossing; code also raises ringRelay when powerDown clears with relay_reg set.
// R18 - Ring relay released on ring trip or ringing bit cleared.
// R19 - Controller keeps normal polarity while ringing is enabled.
// R20 - Ring trip from start/end comparison of integrated line current.
// R21 - Power down on overtemperature or command; drivers released.
// R22 - Logic resets at power on and on tax pin reset level.
// R23 - Select rising before eight write bits discards the partial byte.
module lcsc_serial_control (
  input wire logic clock,
  input wire logic rst,
  input wire logic shiftClk,
  input wire logic chipSelN,
  input wire logic readWriteSel,
  input wire logic serialDataIoIn,
  output logic serialDataIoOut,
  output logic serialDataIoOeN,
  input wire lcsc_pkg::lcsc_line_sense_s lineSense,
  input wire logic ringZeroCross,
  input wire logic ringIntegralDiffers,
  input wire logic ringPeriodEnd,
  input wire logic taxPulseInputReset,
  output lcsc_pkg::lcsc_line_drive_s lineDrive
);

  // Every assertion below shares this clock and reset
  default clocking assertClk @(posedge clock);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  localparam int NSYNC = 9;
  logic [NSYNC-1:0] syncA_reg;
  logic [NSYNC-1:0] syncB_reg;
  logic [NSYNC-1:0] rawIn;
  assign rawIn = {shiftClk, chipSelN, readWriteSel, serialDataIoIn,
                  lineSense, taxPulseInputReset};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      syncA_reg <= '1;
      syncB_reg <= '1;
    end else begin
      syncA_reg <= rawIn;
      syncB_reg <= syncA_reg;
    end
  end

  logic sClk, sCsN, sRw, sData, sHook, sCmp, sGk, sTw, sTaxRst;
  assign {sClk, sCsN, sRw, sData, sHook, sCmp, sGk, sTw, sTaxRst}
    = syncB_reg;

  logic [1:0] ringSyncA_reg;
  logic [1:0] ringSyncB_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ringSyncA_reg <= 2'h0;
      ringSyncB_reg <= 2'h0;
    end else begin
      ringSyncA_reg <= {ringZeroCross, ringIntegralDiffers};
      ringSyncB_reg <= ringSyncA_reg;
    end
  end
  logic sZero, sDiff;
  assign {sZero, sDiff} = ringSyncB_reg;

  logic endSyncA_reg, endSyncB_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      endSyncA_reg <= 1'b0;
      endSyncB_reg <= 1'b0;
    end else begin
      endSyncA_reg <= ringPeriodEnd;
      endSyncB_reg <= endSyncA_reg;
    end
  end

  // ==========================================================
  // Edge detection and internal reset
  // ==========================================================
  logic clkPrev_reg, csPrev_reg, endPrev_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clkPrev_reg <= 1'b1;
      csPrev_reg <= 1'b1;
      endPrev_reg <= 1'b0;
    end else begin
      clkPrev_reg <= sClk;
      csPrev_reg <= sCsN;
      endPrev_reg <= endSyncB_reg;
    end
  end

  logic clkRise, csRise, periodEnd, logicReset;
  assign clkRise = sClk && !clkPrev_reg;
  assign csRise = sCsN && !csPrev_reg;
  assign periodEnd = endSyncB_reg && !endPrev_reg;
  assign logicReset = sTaxRst; // see R22

  // ==========================================================
  // Serial shifter
  // ==========================================================
  logic [7:0] rxShift_reg;
  logic [3:0] bitCount_reg;
  logic [11:0] txShift_reg;
  logic [7:0] feed_reg, ctrl_reg, echo_reg;
  logic [11:0] statusWord;

  assign statusWord = {echo_reg, sTw, sGk, sCmp, sHook}; // see R14 R15 R16

  logic csLowRead;
  assign csLowRead = !sCsN && !sRw;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rxShift_reg <= 8'h00;
      bitCount_reg <= 4'h0;
      txShift_reg <= 12'h000;
    end else if (logicReset || sCsN) begin
      bitCount_reg <= 4'h0;
      txShift_reg <= statusWord;
    end else if (clkRise) begin
      if (sRw) begin
        // LSB first: new bit enters the top, bit zero ends at bit 0
        rxShift_reg <= {sData, rxShift_reg[7:1]}; // see R1 R6
        if (bitCount_reg <= lcsc_pkg::WRITE_LAST)
          bitCount_reg <= bitCount_reg + 4'h1;
      end else begin
        // First rise repeats bit zero, later rises advance
        if (bitCount_reg != 4'h0)
          txShift_reg <= {1'b0, txShift_reg[11:1]}; // see R2 R3 R6
        if (bitCount_reg <= lcsc_pkg::STATUS_LAST)
          bitCount_reg <= bitCount_reg + 4'h1;
      end
    end
  end

  // Pin driven only in read with select low, released otherwise
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serialDataIoOut <= 1'b0;
      serialDataIoOeN <= 1'b1;
    end else begin
      serialDataIoOeN <= !csLowRead; // see R4
      serialDataIoOut <= csLowRead ? txShift_reg[0] : 1'b0; // see R3
    end
  end

  // ==========================================================
  // Register commit
  // ==========================================================
  logic commitOk;
  assign commitOk = csRise && sRw
    && bitCount_reg == 4'(lcsc_pkg::WRITE_BITS)       // see R23
    && rxShift_reg[lcsc_pkg::VALID_BIT];              // see R8

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      feed_reg <= lcsc_pkg::FEED_RESET;
      ctrl_reg <= lcsc_pkg::CTRL_RESET;
      echo_reg <= lcsc_pkg::ECHO_RESET;
    end else if (logicReset) begin
      feed_reg <= lcsc_pkg::FEED_RESET;
      ctrl_reg <= lcsc_pkg::CTRL_RESET;
      echo_reg <= lcsc_pkg::ECHO_RESET;
    end else if (commitOk) begin
      echo_reg <= rxShift_reg; // see R15
      if (rxShift_reg[lcsc_pkg::SEL_BIT] == lcsc_pkg::SEL_FEED)
        feed_reg <= rxShift_reg; // see R7
      else
        ctrl_reg <= rxShift_reg; // see R7
    end
  end

  // ==========================================================
  // Ring relay
  // ==========================================================
  // Trip latches until software drops ringing, so the relay cannot
  // re-close on the next zero crossing against an off-hook line.
  logic relay_reg, tripped_reg;
  logic ringOn;
  assign ringOn = ctrl_reg[lcsc_pkg::CTRL_RING];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      relay_reg <= 1'b0;
      tripped_reg <= 1'b0;
    end else if (logicReset || !ringOn) begin
      relay_reg <= 1'b0; // see R18
      tripped_reg <= 1'b0;
    end else if (periodEnd && sDiff) begin
      relay_reg <= 1'b0; // see R18 R20
      tripped_reg <= 1'b1;
    end else if (!relay_reg && !tripped_reg && sZero) begin
      relay_reg <= 1'b1; // see R17
    end
  end

  // ==========================================================
  // Line state decode
  // ==========================================================
  logic [5:0] limitMa;
  logic cmdPowerDown, powerDown;
  assign limitMa =
    (feed_reg[lcsc_pkg::FEED_LIM30] ? lcsc_pkg::LIMIT_STEP30 : 6'h00)
    + (feed_reg[lcsc_pkg::FEED_LIM20] ? lcsc_pkg::LIMIT_STEP20 : 6'h00)
    + (feed_reg[lcsc_pkg::FEED_LIM12] ? lcsc_pkg::LIMIT_STEP12 : 6'h00);
  assign cmdPowerDown = feed_reg[lcsc_pkg::FEED_STANDBY]
    && feed_reg[6:4] == 3'h0; // see R11
  assign powerDown = cmdPowerDown || sTw; // see R21

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lineDrive <= '0;
      lineDrive.powerDownState <= 1'b1;
    end else begin
      lineDrive.powerDownState <= powerDown; // see R21
      lineDrive.standbyState <= !powerDown
        && feed_reg[lcsc_pkg::FEED_STANDBY]; // see R9
      lineDrive.talkState <= !powerDown
        && !feed_reg[lcsc_pkg::FEED_STANDBY];
      lineDrive.specialChar <= feed_reg[lcsc_pkg::FEED_SPECIAL];
      lineDrive.realBattery <= feed_reg[lcsc_pkg::FEED_REAL_BATT];
      lineDrive.currentLimitMa <= limitMa; // see R10
      lineDrive.generalPurposeOutput <= ctrl_reg[lcsc_pkg::CTRL_GPO];
      lineDrive.analogIoOutMode <= ctrl_reg[lcsc_pkg::CTRL_AIO_OUT];
      lineDrive.taxPulseOn <= ctrl_reg[lcsc_pkg::CTRL_TAX_ON]; // see R12
      lineDrive.reverseBattery <= ctrl_reg[lcsc_pkg::CTRL_REVERSE];
      lineDrive.taxDropNoVariation <= ctrl_reg[lcsc_pkg::CTRL_TAX_NOVAR];
      lineDrive.ringRelay <= relay_reg && !powerDown; // see R13
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  a_pin_release: assert property (sCsN |=> serialDataIoOeN) // see R4
    else $error("data pin driven while deselected");
  a_read_drive: assert property (csLowRead |=> !serialDataIoOeN) // see R2
    else $error("data pin not driven during read");
  a_first_repeat: assert property (clkRise && csLowRead // see R3
    && !logicReset && bitCount_reg == 4'h0 |=> $stable(txShift_reg))
    else $error("first rise did not repeat bit zero");
  a_bit_zero_early: assert property ($rose(csLowRead) // see R3
    |=> serialDataIoOut == $past(txShift_reg[0]))
    else $error("bit zero not presented at select");
  a_partial_drop: assert property (csRise && !logicReset // see R23
    && bitCount_reg != 4'h8 |=> $stable(echo_reg))
    else $error("partial byte committed");
  a_invalid_drop: assert property (csRise && !logicReset // see R8
    && !rxShift_reg[7] |=> $stable(feed_reg) && $stable(ctrl_reg))
    else $error("byte without validation committed");
  a_commit_sel: assert property (commitOk && !logicReset // see R7
    && rxShift_reg[0] |=> ctrl_reg == $past(rxShift_reg))
    else $error("control byte not committed");
  a_commit_feed: assert property (commitOk && !logicReset // see R7
    && !rxShift_reg[0] |=> feed_reg == $past(rxShift_reg))
    else $error("feed byte not committed");
  a_echo_last: assert property (commitOk && !logicReset // see R15
    |=> echo_reg == $past(rxShift_reg))
    else $error("echo not updated by commit");
  a_relay_zero: assert property ($rose(relay_reg) // see R17
    |-> $past(sZero) && $past(ringOn))
    else $error("relay closed off zero crossing");
  a_relay_drop: assert property (!ringOn |=> !relay_reg) // see R18
    else $error("relay held with ringing off");
  a_trip_open: assert property (periodEnd && sDiff |=> !relay_reg) // see R20
    else $error("relay held after ring trip");
  a_power_down: assert property (cmdPowerDown // see R11
    |=> lineDrive.powerDownState)
    else $error("power down not entered");
  a_thermal_down: assert property (sTw // see R21
    |=> lineDrive.powerDownState)
    else $error("power down not entered on overtemperature");
  c_write: cover property (commitOk);
  c_read: cover property (csLowRead && clkRise && bitCount_reg == 4'hB);
  c_trip: cover property ($fell(relay_reg) && ringOn);
  c_close: cover property ($rose(relay_reg));

endmodule : lcsc_serial_control

/* File: testbench/lcsc_line_card_ctrl.sv */
/*
  Line card controller model: drives the four-wire serial bus of the
  line card serial control block and resolves the shared data pin.
  Assumes the device clock runs at 40 MHz, falling edges used here.
*/
module lcsc_line_card_ctrl (
  input wire logic clock,
  input wire logic serialDataIoOut,
  input wire logic serialDataIoOeN,
  output logic shiftClk,
  output logic chipSelN,
  output logic readWriteSel,
  output logic serialDataIoIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drv = 1'b0;
  logic drvBit = 1'b0;
  logic lastLevel = 1'b0;
  initial begin
    shiftClk = 1'b0;
    chipSelN = 1'b1;
    readWriteSel = 1'b1;
  end
  // Released pin toggles so a stale bit never passes for data
  assign serialDataIoIn = drv ? drvBit :
    (!serialDataIoOeN ? serialDataIoOut : ~lastLevel);
  always @(posedge clock) lastLevel <= serialDataIoIn;
  // ==========================================================
  // Bus cycles, 200 ns shift clock
  // ==========================================================
  // Faster than the field limit to keep runs short; the design only
  // needs four clocks a phase
  task half;
    repeat (4) @(negedge clock);
  endtask : half
  task pulse;
    shiftClk = 1'b1;
    half();
    shiftClk = 1'b0;
    half();
  endtask : pulse
  task write_bits(input logic [7:0] b, input int n);
    @(negedge clock);
    readWriteSel = 1'b1;
    chipSelN = 1'b0;
    drv = 1'b1;
    repeat (4) @(negedge clock);
    for (int i = 0; i < n; i++) begin
      drvBit = b[i];
      half();
      shiftClk = 1'b1;
      half();
      shiftClk = 1'b0;
    end
    chipSelN = 1'b1;
    drv = 1'b0;
    repeat (16) @(negedge clock);
  endtask : write_bits
  task read_word(output logic [11:0] w, output logic first);
    @(negedge clock);
    readWriteSel = 1'b0;
    chipSelN = 1'b0;
    repeat (8) @(negedge clock);
    first = serialDataIoIn;
    for (int i = 0; i < 12; i++) begin
      pulse();
      w[i] = serialDataIoIn;
    end
    chipSelN = 1'b1;
    readWriteSel = 1'b1;
    repeat (8) @(negedge clock);
  endtask : read_word
endmodule : lcsc_line_card_ctrl

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the line card serial control block with a
  register model in integers compared after each random write pair, the partial write, and the thermal and reset steps.
  Assumes the controller model drives the serial bus.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic shiftClk, chipSelN, readWriteSel;
  logic serialDataIoIn, serialDataIoOut, serialDataIoOeN;
  logic ringZeroCross = 1'b0;
  logic ringIntegralDiffers = 1'b0;
  logic ringPeriodEnd = 1'b0;
  logic taxPulseInputReset = 1'b0;
  lcsc_pkg::lcsc_line_sense_s lineSense = '0;
  lcsc_pkg::lcsc_line_drive_s lineDrive;
  int nMismatch = 0;
  int nChecks = 0;
  int seed = 32'ha2b3_bb3d;
  int feedM, ctrlM, echoM;
  logic [31:0] r;
  always #12.5 clock = ~clock;
  lcsc_serial_control uut (.clock(clock), .rst(rst), .shiftClk(shiftClk),
    .chipSelN(chipSelN), .readWriteSel(readWriteSel),
    .serialDataIoIn(serialDataIoIn), .serialDataIoOut(serialDataIoOut),
    .serialDataIoOeN(serialDataIoOeN), .lineSense(lineSense),
    .ringZeroCross(ringZeroCross), .ringIntegralDiffers(ringIntegralDiffers),
    .ringPeriodEnd(ringPeriodEnd), .taxPulseInputReset(taxPulseInputReset),
    .lineDrive(lineDrive));
  lcsc_line_card_ctrl ctrl (.clock(clock), .serialDataIoOut(serialDataIoOut),
    .serialDataIoOeN(serialDataIoOeN), .shiftClk(shiftClk),
    .chipSelN(chipSelN), .readWriteSel(readWriteSel),
    .serialDataIoIn(serialDataIoIn));
  // ==========================================================
  // Checking and model
  // ==========================================================
  task results;
    if (nMismatch == 0 && nChecks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task check(input string name, input logic [11:0] seen,
             input logic [11:0] exp);
    nChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task model_write(input logic [7:0] b, input int n);
    ctrl.write_bits(b, n);
    if (n == 8 && b[7]) begin
      if (b[0]) ctrlM = b;
      else feedM = b;
      echoM = b;
    end
  endtask : model_write
  task check_drive;
    logic [7:0] f, c;
    int lim;
    logic pdE;
    logic [1:0] modeE, modeSeen, feedSeen;
    logic [4:0] ctlSeen;
    f = feedM[7:0];
    c = ctrlM[7:0];
    lim = 30 * f[4] + 20 * f[5] + 12 * f[6];
    pdE = (f[1] && f[6:4] == 3'h0) || lineSense.thermalOver;
    modeE = pdE ? 2'b00 : {f[1], !f[1]};
    modeSeen = {lineDrive.standbyState, lineDrive.talkState};
    feedSeen = {lineDrive.specialChar, lineDrive.realBattery};
    ctlSeen = {lineDrive.generalPurposeOutput, lineDrive.analogIoOutMode,
      lineDrive.taxPulseOn, lineDrive.reverseBattery,
      lineDrive.taxDropNoVariation};
    check("powerDown", lineDrive.powerDownState, pdE);
    check("mode", modeSeen, modeE);
    check("feed", feedSeen, {f[2], f[3]});
    check("limit", lineDrive.currentLimitMa, lim[11:0]);
    check("ctrl", ctlSeen, {c[1], c[2], c[3], c[4], c[6]});
  endtask : check_drive
  task check_status;
    logic [11:0] w;
    logic [11:0] want;
    logic first;
    r = $random(seed);
    lineSense = lcsc_pkg::lcsc_line_sense_s'(r[3:0]);
    want = {echoM[7:0], lineSense.thermalOver, lineSense.groundKeyFlag,
      lineSense.compareResult, lineSense.hookState};
    ctrl.read_word(w, first);
    check("status", w, want);
    check("firstBit", first, lineSense.hookState);
    check("pinIdle", serialDataIoOeN, 1'b1);
  endtask : check_status
  task ring_check(input logic exp);
    repeat (8) @(negedge clock);
    check("ringRelay", lineDrive.ringRelay, exp);
  endtask : ring_check
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    feedM = 2;
    ctrlM = 1;
    echoM = 0;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    check_drive;
    check_status;
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      model_write({1'b1, r[6:1], 1'b0}, 8);
      model_write({1'b1, r[13], 1'b0, r[11:8], 1'b1}, 8);
      check_drive;
      check_status;
    end
    lineSense = '0;
    model_write(8'h31, 8);
    model_write(8'hFF, 5);
    check_drive;
    // Ringing only with direct battery, bit four kept clear
    model_write(8'h90, 8);
    model_write(8'hA1, 8);
    ring_check(1'b0);
    ringZeroCross = 1'b1;
    ring_check(1'b1);
    ringZeroCross = 1'b0;
    ringIntegralDiffers = 1'b1;
    ringPeriodEnd = 1'b1;
    ring_check(1'b0);
    ringPeriodEnd = 1'b0;
    ringIntegralDiffers = 1'b0;
    model_write(8'h81, 8);
    model_write(8'hA1, 8);
    ringZeroCross = 1'b1;
    ring_check(1'b1);
    ringZeroCross = 1'b0;
    model_write(8'h81, 8);
    ring_check(1'b0);
    lineSense.thermalOver = 1'b1;
    repeat (8) @(negedge clock);
    check_drive;
    lineSense.thermalOver = 1'b0;
    taxPulseInputReset = 1'b1;
    repeat (6) @(negedge clock);
    taxPulseInputReset = 1'b0;
    feedM = 2;
    ctrlM = 1;
    echoM = 0;
    repeat (6) @(negedge clock);
    check_drive;
    check_status;
    results;
  end
  initial begin
    #1_000_000;
    nMismatch++;
    results;
  end
endmodule : testbench
